/* File: rtl/adt_pkg.sv */
// Package: register map, field layout, reset values and filter constants
package adt_pkg;
    // =====================================================================
    // Register offsets
    localparam logic [7:0] ADDR_GAIN_CONTROL_CFG    = 8'h01;
    localparam logic [7:0] ADDR_POSTFILTER_RATE_CFG = 8'h03;
    localparam logic [7:0] ADDR_THRESHOLD_FLOOR_CFG = 8'h04;
    localparam logic [7:0] ADDR_PEAK_DETECTOR_CFG   = 8'h05;
    localparam logic [7:0] ADDR_THRESHOLD_METHOD    = 8'h06;
    localparam logic [7:0] ADDR_POSTFILTER_SAMPLE   = 8'h12;

    // =====================================================================
    // Field positions
    localparam int METHOD_SEL_BIT = 7;   // threshold_method_cfg
    localparam int LP_BW_BIT      = 6;   // threshold_method_cfg
    localparam int GAIN_LSB       = 0;   // threshold_method_cfg [4:0]
    localparam int DISCH_LSB      = 5;   // peak_detector_cfg [6:5]
    localparam int TC_LSB         = 0;   // peak_detector_cfg [4:0]

    // =====================================================================
    // Reset values
    localparam logic [7:0] RST_GAIN_CONTROL = 8'h00;
    localparam logic [7:0] RST_RATE_CFG     = 8'h00;
    localparam logic [7:0] RST_FLOOR        = 8'h81;   // -127
    localparam logic [7:0] RST_PEAK_CFG     = 8'h14;
    localparam logic [7:0] RST_METHOD       = 8'h0b;

    // =====================================================================
    // Filter arithmetic
    localparam int FRAC_BITS      = 8;   // fraction bits of the filter state
    localparam int LP_SHIFT_BASE  = 3;   // lowpass step shift, wide bandwidth
    localparam int PD_SHIFT_BASE  = 1;   // least peak discharge shift
    localparam int GAIN_SHIFT     = 4;   // gain code is a fraction of 16

    // Threshold methods
    typedef enum logic {
        ADT_PRECHARGED_LOWPASS_METHOD = 1'b0,
        ADT_ADAPTIVE_PEAK_METHOD      = 1'b1
    } adt_method_t;
endpackage : adt_pkg

/* File: rtl/adt_peak_det.sv */
// Adaptive peak detector with programmable discharge
`timescale 1ns/1ps
`default_nettype none
module adt_peak_det
    import adt_pkg::*;
(
    input  wire logic               ref_clk_i,
    input  wire logic               srst_i,
    input  wire logic               precharge_i,
    input  wire logic               sample_valid_i,
    input  wire logic signed [7:0]  sample_i,
    input  wire logic        [1:0]  peak_discharge_sel_i,
    input  wire logic        [4:0]  peak_time_const_i,
    output logic signed     [15:0]  peak_o
);
    // =====================================================================
    // Decay shift: longer time constant and discharge setting mean slower
    logic        [3:0]  dec_shift;
    logic signed [15:0] x_ext;
    logic signed [16:0] diff;
    logic signed [16:0] step;
    logic signed [15:0] peak_reg;
    logic signed [15:0] peak_next;

    assign dec_shift = 4'(PD_SHIFT_BASE) + {1'b0, peak_time_const_i[4:2]}
                       + {2'b00, peak_discharge_sel_i};
    assign x_ext     = {sample_i, 8'h00};
    assign diff      = 17'(x_ext) - 17'(peak_reg);
    assign step      = diff >>> dec_shift;

    // Instant attack on a higher sample, exponential discharge otherwise
    assign peak_next = precharge_i         ? x_ext :
                       (diff > 17'sd0)     ? x_ext :
                       16'(17'(peak_reg) + step);

    // State update only on new samples
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            peak_reg <= 16'sh0000;
        end else if (sample_valid_i) begin
            peak_reg <= peak_next;
        end
    end

    assign peak_o = peak_reg;

    // Peak never drops below a newer, larger sample
    property p_peak_attack;
        @(posedge ref_clk_i) disable iff (srst_i)
        (sample_valid_i && (x_ext > peak_reg)) |=> (peak_reg == $past(x_ext));
    endproperty
    a_peak_attack: assert property (p_peak_attack)
        else $error("peak detector missed a rising sample");
endmodule // adt_peak_det
`default_nettype wire

/* File: rtl/adt_threshold.sv */
// Amplitude-keyed decision threshold generator and data slicer
// =========================================================================
`timescale 1ns/1ps
`default_nettype none
module adt_threshold
    import adt_pkg::*;
(
    input  wire logic               ref_clk_i,
    input  wire logic               srst_i,
    input  wire logic               ask_mode_i,
    input  wire logic               sample_valid_i,
    input  wire logic signed [7:0]  sample_i,
    input  wire logic        [7:0]  reg_addr_i,
    input  wire logic        [7:0]  reg_wdata_i,
    input  wire logic               reg_wr_i,
    input  wire logic               reg_rd_i,
    output logic             [7:0]  reg_rdata_o,
    output logic signed      [7:0]  threshold_o,
    output logic                    data_o
);
    // =====================================================================
    // Register file
    logic [7:0] gain_control_cfg_reg;
    logic [7:0] postfilter_rate_cfg_reg;
    logic [7:0] threshold_floor_cfg_reg;
    logic [7:0] peak_detector_cfg_reg;
    logic [7:0] threshold_method_cfg_reg;
    logic [7:0] postfilter_sample_reg;
    logic [7:0] rdata_next;

    // Register writes; unmapped and read-only offsets ignore the write
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            gain_control_cfg_reg     <= RST_GAIN_CONTROL;
            postfilter_rate_cfg_reg  <= RST_RATE_CFG;
            threshold_floor_cfg_reg  <= RST_FLOOR;
            peak_detector_cfg_reg    <= RST_PEAK_CFG;
            threshold_method_cfg_reg <= RST_METHOD;
        end else if (reg_wr_i) begin
            unique case (reg_addr_i)
                ADDR_GAIN_CONTROL_CFG:    gain_control_cfg_reg     <= reg_wdata_i;
                ADDR_POSTFILTER_RATE_CFG: postfilter_rate_cfg_reg  <= reg_wdata_i;
                ADDR_THRESHOLD_FLOOR_CFG: threshold_floor_cfg_reg  <= reg_wdata_i;
                ADDR_PEAK_DETECTOR_CFG:   peak_detector_cfg_reg    <= reg_wdata_i;
                ADDR_THRESHOLD_METHOD:    threshold_method_cfg_reg <= reg_wdata_i;
                default: ;
            endcase
        end
    end

    // Read mux; unmapped offsets read zero
    always_comb begin
        unique case (reg_addr_i)
            ADDR_GAIN_CONTROL_CFG:    rdata_next = gain_control_cfg_reg;
            ADDR_POSTFILTER_RATE_CFG: rdata_next = postfilter_rate_cfg_reg;
            ADDR_THRESHOLD_FLOOR_CFG: rdata_next = threshold_floor_cfg_reg;
            ADDR_PEAK_DETECTOR_CFG:   rdata_next = peak_detector_cfg_reg;
            ADDR_THRESHOLD_METHOD:    rdata_next = threshold_method_cfg_reg;
            ADDR_POSTFILTER_SAMPLE:   rdata_next = postfilter_sample_reg;
            default:                  rdata_next = 8'h00;
        endcase
    end

    // Read data and sample snapshot; the snapshot lets the host calibrate
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            reg_rdata_o           <= 8'h00;
            postfilter_sample_reg <= 8'h00;
        end else begin
            if (reg_rd_i) begin
                reg_rdata_o <= rdata_next;
            end
            if (sample_valid_i) begin
                postfilter_sample_reg <= sample_i;
            end
        end
    end

    // =====================================================================
    // Field decode
    adt_method_t        method;
    logic               lowpass_bw_sel;
    logic        [4:0]  threshold_gain_code;
    logic        [1:0]  peak_discharge_sel;
    logic        [4:0]  peak_time_const;
    logic signed [7:0]  threshold_floor;

    assign method              = adt_method_t'(threshold_method_cfg_reg[METHOD_SEL_BIT]);
    assign lowpass_bw_sel      = threshold_method_cfg_reg[LP_BW_BIT];
    assign threshold_gain_code = threshold_method_cfg_reg[GAIN_LSB +: 5];
    assign peak_discharge_sel  = peak_detector_cfg_reg[DISCH_LSB +: 2];
    assign peak_time_const     = peak_detector_cfg_reg[TC_LSB +: 5];
    assign threshold_floor     = threshold_floor_cfg_reg;

    // =====================================================================
    // Precharge: first sample after a method change or any ASK/FSK mode change
    // loads the active filter directly, so settling starts from the signal
    logic method_seen_reg;
    logic ask_seen_reg;
    logic primed_reg;
    logic precharge;

    assign precharge = sample_valid_i && !primed_reg;

    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            method_seen_reg <= 1'b0;
            ask_seen_reg    <= 1'b0;
            primed_reg      <= 1'b0;
        end else begin
            method_seen_reg <= method;
            ask_seen_reg    <= ask_mode_i;
            if ((method != method_seen_reg) || (ask_mode_i != ask_seen_reg)) begin
                primed_reg <= 1'b0;
            end else if (sample_valid_i) begin
                primed_reg <= 1'b1;
            end
        end
    end

    // =====================================================================
    // Precharged lowpass: step shift grows by one for the narrow setting
    logic        [2:0]  lp_shift;
    logic signed [15:0] x_ext;
    logic signed [16:0] lp_diff;
    logic signed [15:0] lp_reg;
    logic signed [15:0] lp_next;

    assign lp_shift = 3'(LP_SHIFT_BASE) + {2'b00, lowpass_bw_sel};
    assign x_ext    = {sample_i, 8'h00};
    assign lp_diff  = 17'(x_ext) - 17'(lp_reg);
    assign lp_next  = precharge ? x_ext : 16'(17'(lp_reg) + (lp_diff >>> lp_shift));

    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            lp_reg <= 16'sh0000;
        end else if (sample_valid_i && (method == ADT_PRECHARGED_LOWPASS_METHOD)) begin
            lp_reg <= lp_next;
        end
    end

    // =====================================================================
    // Adaptive peak detector; only clocked while its method is chosen
    logic signed [15:0] peak_level;

    adt_peak_det u_peak_det (
        .ref_clk_i            (ref_clk_i),
        .srst_i               (srst_i),
        .precharge_i          (precharge),
        .sample_valid_i       (sample_valid_i && (method == ADT_ADAPTIVE_PEAK_METHOD)),
        .sample_i             (sample_i),
        .peak_discharge_sel_i (peak_discharge_sel),
        .peak_time_const_i    (peak_time_const),
        .peak_o               (peak_level)
    );

    // =====================================================================
    // Threshold: scaled level, saturated to 8 bits, held above the floor in ASK mode; zero in FSK mode
    logic signed [7:0]  level;
    logic signed [13:0] scaled;
    logic signed [13:0] shifted;
    logic signed [7:0]  raw_thr;
    logic signed [7:0]  ask_thr;
    logic signed [7:0]  thr_next;

    assign level    = (method == ADT_PRECHARGED_LOWPASS_METHOD) ?
                      lp_reg[15:FRAC_BITS] : peak_level[15:FRAC_BITS];
    assign scaled   = level * $signed({1'b0, threshold_gain_code});
    assign shifted  = scaled >>> GAIN_SHIFT;
    assign raw_thr  = (shifted > 14'sd127)  ? 8'sh7f :
                      (shifted < -14'sd128) ? 8'sh80 : shifted[7:0];
    assign ask_thr  = (raw_thr < threshold_floor) ? threshold_floor : raw_thr;
    assign thr_next = ask_mode_i ? ask_thr : 8'sh00;

    // Threshold follows every cycle; data slices only on new samples
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            threshold_o <= 8'sh00;
            data_o      <= 1'b0;
        end else begin
            threshold_o <= thr_next;
            if (sample_valid_i) begin
                data_o <= (sample_i > threshold_o);
            end
        end
    end

    // =====================================================================
    // Assertions
    property p_floor_hold;
        @(posedge ref_clk_i) disable iff (srst_i)
        (ask_mode_i && $stable(threshold_floor) && !$rose(ask_mode_i))
            |=> (threshold_o >= $past(threshold_floor));
    endproperty
    a_floor_hold: assert property (p_floor_hold)
        else $error("threshold fell below the floor");

    property p_fsk_zero;
        @(posedge ref_clk_i) disable iff (srst_i)
        !ask_mode_i |=> (threshold_o == 8'sh00);
    endproperty
    a_fsk_zero: assert property (p_fsk_zero)
        else $error("FSK threshold not zero");

    property p_slice;
        @(posedge ref_clk_i) disable iff (srst_i)
        sample_valid_i |=> (data_o == ($past(sample_i) > $past(threshold_o)));
    endproperty
    a_slice: assert property (p_slice)
        else $error("data bit disagrees with comparison");

    property p_data_hold;
        @(posedge ref_clk_i) disable iff (srst_i)
        !sample_valid_i |=> $stable(data_o);
    endproperty
    a_data_hold: assert property (p_data_hold)
        else $error("data changed without a sample");

    property p_method_lp;
        @(posedge ref_clk_i) disable iff (srst_i)
        (method == ADT_PRECHARGED_LOWPASS_METHOD) && sample_valid_i
            |=> $stable(peak_level);
    endproperty
    a_method_lp: assert property (p_method_lp)
        else $error("peak detector moved under lowpass method");

    property p_method_pd;
        @(posedge ref_clk_i) disable iff (srst_i)
        (method == ADT_ADAPTIVE_PEAK_METHOD) |=> $stable(lp_reg);
    endproperty
    a_method_pd: assert property (p_method_pd)
        else $error("lowpass moved under peak method");

    property p_precharge;
        @(posedge ref_clk_i) disable iff (srst_i)
        precharge && (method == ADT_PRECHARGED_LOWPASS_METHOD)
            |=> (lp_reg[15:FRAC_BITS] == $past(sample_i));
    endproperty
    a_precharge: assert property (p_precharge)
        else $error("lowpass not precharged by first sample");

    property p_squelch;
        @(posedge ref_clk_i) disable iff (srst_i)
        (ask_mode_i && sample_valid_i && (sample_i <= threshold_floor)
            && (threshold_o >= threshold_floor)) |=> !data_o;
    endproperty
    a_squelch: assert property (p_squelch)
        else $error("data toggled below the floor");

    property p_snapshot;
        @(posedge ref_clk_i) disable iff (srst_i)
        sample_valid_i ##1 (reg_rd_i && (reg_addr_i == ADDR_POSTFILTER_SAMPLE)
            && !sample_valid_i) |=> (reg_rdata_o == $past(sample_i, 2));
    endproperty
    a_snapshot: assert property (p_snapshot)
        else $error("sample read back wrong");
endmodule // adt_threshold
`default_nettype wire

/* File: verif/adt_host_model.sv */
// Host model: microcontroller that programs and reads the threshold registers
`timescale 1ns/1ps
`default_nettype none
module adt_host_model
    import adt_pkg::*;
(
    input  wire logic       ref_clk_i,
    input  wire logic [7:0] reg_rdata_i,
    output logic      [7:0] reg_addr_o,
    output logic      [7:0] reg_wdata_o,
    output logic            reg_wr_o,
    output logic            reg_rd_o
);
    // =====================================================================
    // Idle bus from time zero
    initial begin
        reg_addr_o  = 8'h00;
        reg_wdata_o = 8'h00;
        reg_wr_o    = 1'b0;
        reg_rd_o    = 1'b0;
    end

    // One-cycle write; address and data scrambled after release so stale values never match
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk_i);
        reg_addr_o  <= a;
        reg_wdata_o <= d;
        reg_wr_o    <= 1'b1;
        @(posedge ref_clk_i);
        reg_wr_o    <= 1'b0;
        reg_addr_o  <= ~a;
        reg_wdata_o <= ~d;
    endtask

    // One-cycle read; data settles after the taking edge
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge ref_clk_i);
        reg_addr_o <= a;
        reg_rd_o   <= 1'b1;
        @(posedge ref_clk_i);
        reg_rd_o   <= 1'b0;
        reg_addr_o <= ~a;
        #1;
        d = reg_rdata_i;
    endtask

    // Threshold setup chosen from the expected traffic and filter plan
    task automatic setup(input logic m, input logic bw, input logic [1:0] dt,
                         input logic [4:0] tc, input logic [4:0] gc, input logic [7:0] fl);
        wr(ADDR_THRESHOLD_FLOOR_CFG, fl);
        wr(ADDR_PEAK_DETECTOR_CFG, {1'b0, dt, tc});
        wr(ADDR_THRESHOLD_METHOD, {m, bw, 1'b0, gc});
    endtask

    // Uncalibrated floor from the two looked-up (already rounded) noise offsets
    function automatic logic [7:0] default_floor(input int mu_f, input int mu_r);
        return 8'(mu_f + mu_r - 6);
    endfunction
endmodule // adt_host_model
`default_nettype wire

/* File: verif/ask_decision_threshold_bench.sv */
// Testbench: threshold generator against a behavioural filter model
`timescale 1ns/1ps
`default_nettype none
module ask_decision_threshold_bench
    import adt_pkg::*;
;
    logic              clk, srst, ask, valid;
    logic signed [7:0] samp;
    logic        [7:0] addr, wdata, rdata, v;
    logic              wr, rd, dat;
    logic signed [7:0] thr_o;
    int                error_cnt = 0, comparisons = 0;
    int                lp_s, pk_s, thr, fl;
    logic              pre, meth, bw;
    logic        [1:0] dt;
    logic        [4:0] tc, gc;
    logic        [4:0] tcs[4] = '{5'h14, 5'h0D, 5'h07, 5'h04};
    logic        [4:0] gcs[4] = '{5'h0B, 5'h09, 5'h06, 5'h04};
    int                seq[13] = '{80, 80, 80, 40, 40, 40, 40, 40, 40, -20, -20, -20, 100};

    adt_host_model host (.ref_clk_i(clk), .reg_rdata_i(rdata), .reg_addr_o(addr),
                         .reg_wdata_o(wdata), .reg_wr_o(wr), .reg_rd_o(rd));
    adt_threshold dut (.ref_clk_i(clk), .srst_i(srst), .ask_mode_i(ask),
                       .sample_valid_i(valid), .sample_i(samp), .reg_addr_i(addr),
                       .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd),
                       .reg_rdata_o(rdata), .threshold_o(thr_o), .data_o(dat));

    // =====================================================================
    // Clock and checking helpers
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch at %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // Reference threshold: gain-scaled level of the active filter, clamped by the floor in ASK mode; zero in FSK mode
    function automatic int lvl_thr();
        int t;
        t = (((meth ? pk_s : lp_s) >>> 8) * int'(gc)) >>> 4;
        // A large gain code must pin the threshold at the 8-bit ends, not wrap
        t = (t > 127) ? 127 : ((t < -128) ? -128 : t);
        if (!ask) return 0;
        return (t < fl) ? fl : t;
    endfunction

    task automatic init_model();
        {lp_s, pk_s, pre, meth, bw, dt, tc, gc, fl} = {32'd0, 32'd0, 1'b1, 1'b0, 1'b0,
                                                       2'd0, 5'h14, 5'h0B, -32'sd127};
        thr = 0;
    endtask

    task automatic cfg(input logic m, input logic b, input logic [1:0] d, input logic [4:0] t,
                       input logic [4:0] g, input logic [7:0] f);
        host.setup(m, b, d, t, g, f);
        if (m != meth) pre = 1'b1;
        {meth, bw, dt, tc, gc} = {m, b, d, t, g};
        fl = int'($signed(f));
        thr = lvl_thr();
    endtask

    // One sample strobe; in ASK mode the model steps the active filter, precharging when due
    task automatic send(input int x);
        int t0;
        t0 = thr;
        @(posedge clk);
        valid <= 1'b1;
        samp  <= 8'(x);
        @(posedge clk);
        valid <= 1'b0;
        samp  <= ~8'(x);
        if (ask && pre) {lp_s, pk_s, pre} = meth ? {lp_s, x * 256, 1'b0} : {x * 256, pk_s, 1'b0};
        else if (ask && meth) pk_s = (x * 256 > pk_s) ? x * 256
                                   : pk_s + ((x * 256 - pk_s) >>> (1 + tc[4:2] + dt));
        else if (ask) lp_s = lp_s + ((x * 256 - lp_s) >>> (3 + bw));
        thr = lvl_thr();
        repeat (2) @(posedge clk);
        #1;
        check(8'(dat), 8'(x > t0));
        check(thr_o, 8'(thr));
    endtask

    // =====================================================================
    // Scenarios
    task automatic t_reset();
        logic [7:0] ra[6] = '{ADDR_GAIN_CONTROL_CFG, ADDR_POSTFILTER_RATE_CFG,
                              ADDR_THRESHOLD_FLOOR_CFG, ADDR_PEAK_DETECTOR_CFG,
                              ADDR_THRESHOLD_METHOD, ADDR_POSTFILTER_SAMPLE};
        logic [7:0] rv[6] = '{RST_GAIN_CONTROL, RST_RATE_CFG, RST_FLOOR, RST_PEAK_CFG,
                              RST_METHOD, 8'h00};
        check(thr_o, 8'h00);
        check(8'(dat), 8'h00);
        for (int i = 0; i < 6; i++) begin
            host.rd(ra[i], v);
            check(v, rv[i]);
        end
        $display("test reset done");
    endtask

    task automatic t_regs();
        host.wr(ADDR_GAIN_CONTROL_CFG, 8'hA5);
        host.wr(ADDR_POSTFILTER_RATE_CFG, 8'h3C);
        host.wr(8'h07, 8'hFF);
        host.rd(ADDR_GAIN_CONTROL_CFG, v);
        check(v, 8'hA5);
        host.rd(ADDR_POSTFILTER_RATE_CFG, v);
        check(v, 8'h3C);
        host.rd(8'h07, v);
        check(v, 8'h00);
        $display("test regs done");
    endtask

    task automatic t_methods();
        for (int m = 0; m < 2; m++) begin
            for (int i = 0; i < 4; i++) begin
                cfg(m[0], i[0], i[1:0], tcs[i], gcs[i], 8'h81);
                for (int k = 0; k < 13; k++) send(seq[k]);
            end
        end
        $display("test methods done");
    endtask

    task automatic t_floor();
        // Full gain on precharged extremes drives both saturation ends
        cfg(1'b0, 1'b0, 2'd0, 5'h14, 5'h1F, 8'h80);
        send(-120);
        cfg(1'b1, 1'b0, 2'd3, 5'h04, 5'h1F, 8'h80);
        send(120);
        cfg(1'b0, 1'b0, 2'd0, 5'h14, 5'h0B, 8'h20);
        foreach (seq[k]) send(k % 3 == 2 ? 40 : 10);
        cfg(1'b1, 1'b0, 2'd3, 5'h04, 5'h0B, 8'h80);
        send(-100);
        send(-100);
        cfg(1'b1, 1'b0, 2'd3, 5'h04, 5'h0B, host.default_floor(-81, 29));
        send(-100);
        host.wr(ADDR_POSTFILTER_SAMPLE, 8'h55);
        host.rd(ADDR_POSTFILTER_SAMPLE, v);
        check(v, 8'h9C);
        $display("test floor done");
    endtask

    task automatic t_fsk();
        @(posedge clk);
        ask <= 1'b0;
        {pre, thr} = {1'b1, 32'd0};
        foreach (seq[k]) send(seq[k] - 60);
        // Read the snapshot in the cycle right after its strobe
        @(posedge clk);
        valid <= 1'b1;
        samp  <= 8'sh2a;
        fork
            host.rd(ADDR_POSTFILTER_SAMPLE, v);
            begin
                @(posedge clk);
                valid <= 1'b0;
            end
        join
        check(v, 8'h2a);
        $display("test fsk done");
    endtask

    task automatic t_reset2();
        @(posedge clk);
        srst <= 1'b1;
        repeat (2) @(posedge clk);
        srst <= 1'b0;
        ask  <= 1'b1;
        init_model();
        @(posedge clk);
        #1;
        t_reset();
        send(50);
        $display("test reset2 done");
    endtask

    // =====================================================================
    // Main sequence and watchdog
    initial begin
        {srst, ask, valid, samp} = {1'b1, 1'b1, 1'b0, 8'h00};
        init_model();
        repeat (16) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        #1;
        t_reset();
        t_regs();
        t_methods();
        t_floor();
        t_fsk();
        t_reset2();
        report_and_stop();
    end

    // Whole run needs about 700 cycles; nearly thirty times that means a hang
    initial begin
        repeat (20000) @(posedge clk);
        error_cnt++;
        report_and_stop();
    end
endmodule // ask_decision_threshold_bench
`default_nettype wire
